// File: hdl/adc_conv_map.svh
// Constants for the converter control block
// Assumes inclusion by package and modules alike
`ifndef ADC_CONV_MAP_SVH
`define ADC_CONV_MAP_SVH
`define RES_BITS 10
`define RES_HIGH_BITS 8
`define RES_LOW_BITS 2
`define START_BIT_POS 7
`define ENABLE_BIT_POS 0
`define CHAN_BITS 3
`define SAMPLE_CYCLES 8
`define SETTLE_CYCLES 5
`define RESULT_RESET 8'h00
`endif

// File: hdl/adc_conv_pkg.sv
// Types for the converter control block
// Assumes adc_conv_map.svh is on the include path
`include "adc_conv_map.svh"
package adc_conv_pkg;
  typedef enum logic [1:0] {
    ST_STOP,
    ST_STANDBY,
    ST_SAMPLE,
    ST_CONVERT
  } conv_state_e;
endpackage : adc_conv_pkg

// File: hdl/adc_conversion_control.sv
// Contract
// - Start bit runs one conversion, then standby
// - Clearing start mid-conversion abandons it
// - Start ignored while enable is low
// - Result split into high eight, low two
// - Result read completes before result write
// - Mode write beats a fresh result write and interrupt, but not a held one
// - Channel change keeps done flag
// - Ten-bit resolution, 1/1024 step
// - Conversion time includes sampling
// - Sample switch closed only while sampling
// - Ideal half-LSB offset transfer
// Control of a 10-bit SAR converter around its comparator
// Assumes mode writes come as one-cycle strobes on mclk
`timescale 1ns/100ps
`default_nettype none
`include "adc_conv_map.svh"
module adc_conversion_control
  import adc_conv_pkg::*;
#(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Mode register write port
  input wire logic modeWrite,
  input wire logic [7:0] modeData,
  // Channel select write port
  input wire logic chanWrite,
  input wire logic [`CHAN_BITS-1:0] chanData,
  // Result read strobes
  input wire logic readHigh,
  input wire logic readLow,
  // Flag clear
  input wire logic flagClear,
  // Comparator, asynchronous
  input wire logic cmpAbove,
  // Analog front end
  output logic sampleSwitch,
  output logic [`RES_BITS-1:0] tapCode,
  output logic [`CHAN_BITS-1:0] channel,
  // Status and results
  output logic conversionStart,
  output logic converterEnable,
  output logic [`RES_HIGH_BITS-1:0] resultHigh,
  output logic [`RES_LOW_BITS-1:0] resultLow,
  output logic conversionDoneIrq,
  output logic conversionDoneFlag
);
  conv_state_e state, next_state;
  logic [15:0] sampleCount, next_sampleCount;
  logic next_start, next_enable, next_switch, next_irq, next_flag;
  logic [`CHAN_BITS-1:0] next_channel;
  logic [`RES_HIGH_BITS-1:0] next_high;
  logic [`RES_LOW_BITS-1:0] next_low;
  logic [`RES_BITS-1:0] heldResult, next_heldResult;
  logic heldPending, next_heldPending;
  logic cmpS1, cmpS2, cmpS3, cmpStable, next_cmpStable;
  logic sarBegin, sarAbort, sarDone;
  logic [`RES_BITS-1:0] sarTrial, sarValue;
  logic readAny, storeNow;
  logic [2:0] settleCount, next_settleCount;
  logic sarStep;
  logic [`RES_BITS-1:0] storeVal;

  // Comparator synchroniser
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmpS1 <= 1'b0;
      cmpS2 <= 1'b0;
      cmpS3 <= 1'b0;
      cmpStable <= 1'b0;
    end else begin
      cmpS1 <= cmpAbove;
      cmpS2 <= cmpS1;
      cmpS3 <= cmpS2;
      cmpStable <= next_cmpStable;
    end
  end
  assign next_cmpStable = (cmpS2 == cmpS3) ? cmpS3 : cmpStable;

  sar_step #(.WIDTH(`RES_BITS)) u_sar (
    .mclk(mclk),
    .srst(srst),
    .begin_(sarBegin),
    .abort(sarAbort),
    .stepEn(sarStep),
    .cmpAbove(next_cmpStable),
    .trial(sarTrial),
    .done(sarDone),
    .value(sarValue)
  );

  assign readAny = readHigh | readLow;

  always_comb begin
    next_state = state;
    next_sampleCount = sampleCount;
    next_start = conversionStart;
    next_enable = converterEnable;
    next_switch = 1'b0;
    next_irq = 1'b0;
    next_flag = conversionDoneFlag;
    next_channel = channel;
    next_high = resultHigh;
    next_low = resultLow;
    next_heldResult = heldResult;
    next_heldPending = heldPending;
    sarBegin = 1'b0;
    sarAbort = 1'b0;
    storeNow = 1'b0;
    storeVal = heldResult;
    // Step only once tap and synchroniser settled
    sarStep = (settleCount == 3'(`SETTLE_CYCLES - 1));
    next_settleCount = (state != ST_CONVERT || sarStep) ? 3'h0
                                                        : settleCount + 3'h1;
    if (chanWrite) begin
      next_channel = chanData;
    end
    if (flagClear) begin
      next_flag = 1'b0;
    end
    if (modeWrite) begin
      next_enable = modeData[`ENABLE_BIT_POS];
      next_start = modeData[`START_BIT_POS] & modeData[`ENABLE_BIT_POS];
    end
    unique case (state)
      ST_STOP: begin
        if (modeWrite && modeData[`ENABLE_BIT_POS]) begin
          next_state = next_start ? ST_SAMPLE : ST_STANDBY;
          next_switch = next_start;
          next_sampleCount = '0;
        end
      end
      ST_STANDBY: begin
        if (modeWrite) begin
          if (!modeData[`ENABLE_BIT_POS]) begin
            next_state = ST_STOP;
          end else if (next_start) begin
            next_state = ST_SAMPLE;
            next_switch = 1'b1;
            next_sampleCount = '0;
          end
        end
      end
      ST_SAMPLE: begin
        next_switch = 1'b1;
        if (modeWrite && !next_start) begin
          next_switch = 1'b0;
          next_state = next_enable ? ST_STANDBY : ST_STOP;
        end else if (sampleCount == 16'(SAMPLE_CYCLES - 1)) begin
          next_switch = 1'b0;
          sarBegin = 1'b1;
          next_state = ST_CONVERT;
        end else begin
          next_sampleCount = sampleCount + 16'h0001;
        end
      end
      ST_CONVERT: begin
        if (modeWrite) begin
          sarAbort = 1'b1;
          next_state = next_enable ? (next_start ? ST_SAMPLE : ST_STANDBY)
                                   : ST_STOP;
          next_switch = next_enable & next_start;
          next_sampleCount = '0;
        end else if (sarDone) begin
          next_start = 1'b0;
          next_state = ST_STANDBY;
          next_heldResult = sarValue;
          next_heldPending = 1'b1;
        end
      end
    endcase
    if ((heldPending || sarDone && state == ST_CONVERT && !modeWrite)
        && !readAny && !(modeWrite && !heldPending)) begin
      storeNow = 1'b1;
      storeVal = heldPending ? heldResult : sarValue;
      next_heldPending = 1'b0;
    end
    if (storeNow) begin
      next_high = storeVal[`RES_BITS-1:`RES_LOW_BITS];
      next_low = storeVal[`RES_LOW_BITS-1:0];
      next_irq = 1'b1;
      next_flag = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= ST_STOP;
      sampleCount <= '0;
      settleCount <= '0;
      conversionStart <= 1'b0;
      converterEnable <= 1'b0;
      sampleSwitch <= 1'b0;
      conversionDoneIrq <= 1'b0;
      conversionDoneFlag <= 1'b0;
      channel <= '0;
      resultHigh <= `RESULT_RESET;
      resultLow <= '0;
      heldResult <= '0;
      heldPending <= 1'b0;
      tapCode <= '0;
    end else begin
      state <= next_state;
      sampleCount <= next_sampleCount;
      settleCount <= next_settleCount;
      conversionStart <= next_start;
      converterEnable <= next_enable;
      sampleSwitch <= next_switch;
      conversionDoneIrq <= next_irq;
      conversionDoneFlag <= next_flag;
      channel <= next_channel;
      resultHigh <= next_high;
      resultLow <= next_low;
      heldResult <= next_heldResult;
      heldPending <= next_heldPending;
      tapCode <= sarTrial;
    end
  end
endmodule : adc_conversion_control
`default_nettype wire

// File: hdl/sar_step.sv
// Successive-approximation sequencer, one bit per step
// Assumes a comparator answer valid each cycle it is asked
`timescale 1ns/100ps
`default_nettype none
module sar_step #(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control
  input wire logic begin_,
  input wire logic abort,
  input wire logic stepEn,
  // Comparator
  input wire logic cmpAbove,
  output logic [WIDTH-1:0] trial,
  // Result
  output logic done,
  output logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] sar;
  logic [WIDTH-1:0] mask;
  logic busy;
  logic [WIDTH-1:0] next_sar;
  logic [WIDTH-1:0] next_mask;
  logic next_busy;
  logic next_done;

  always_comb begin
    next_sar = sar;
    next_mask = mask;
    next_busy = busy;
    next_done = 1'b0;
    if (abort) begin
      next_busy = 1'b0;
    end else if (begin_) begin
      next_busy = 1'b1;
      next_mask = {1'b1, {(WIDTH-1){1'b0}}};
      next_sar = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (busy && stepEn) begin
      next_sar = cmpAbove ? sar : (sar & ~mask);
      next_mask = mask >> 1;
      next_sar = next_sar | next_mask;
      if (mask[0]) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sar <= '0;
      mask <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      sar <= next_sar;
      mask <= next_mask;
      busy <= next_busy;
      done <= next_done;
    end
  end

  assign trial = sar;
  assign value = next_sar;
endmodule : sar_step
`default_nettype wire

// File: verif/adc_conversion_control_asserts.sv
// Port checker for the converter control block
// Assumes binding onto adc_conversion_control
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_asserts #(
  parameter int SAMPLE_CYCLES = 8
) (
  // Clock, reset and strobes
  input wire logic mclk,
  input wire logic srst,
  input wire logic modeWrite,
  input wire logic [7:0] modeData,
  input wire logic readHigh,
  input wire logic readLow,
  input wire logic flagClear,
  // Status and results
  input wire logic sampleSwitch,
  input wire logic conversionStart,
  input wire logic converterEnable,
  input wire logic [7:0] resultHigh,
  input wire logic [1:0] resultLow,
  input wire logic conversionDoneIrq,
  input wire logic conversionDoneFlag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  irq_one_cycle_a: assert property (conversionDoneIrq |=> !conversionDoneIrq)
    else $error("irq longer than one cycle");
  irq_sets_flag_a: assert property (conversionDoneIrq |-> conversionDoneFlag)
    else $error("flag not set with irq");
  done_clears_start_a: assert property (conversionDoneIrq |-> !conversionStart)
    else $error("start bit left set at done");
  start_enable_a: assert property (conversionStart |-> converterEnable)
    else $error("start set without enable");
  sample_len_a: assert property ($rose(sampleSwitch) |->
    sampleSwitch [*8] ##1 !sampleSwitch)
    else $error("sampling length wrong");
  start_samples_a: assert property ($rose(conversionStart) |-> sampleSwitch)
    else $error("sampling not at start");
  flag_sticky_a: assert property (conversionDoneFlag && !flagClear |=>
    conversionDoneFlag)
    else $error("flag lost without clear");
  read_first_a: assert property (readHigh || readLow |=>
    $stable({resultHigh, resultLow}))
    else $error("result written during read");
  result_irq_a: assert property (!$stable({resultHigh, resultLow}) |->
    conversionDoneIrq)
    else $error("result changed without irq");
  abort_a: assert property (conversionStart && modeWrite && !modeData[7] |=>
    !conversionStart)
    else $error("abort did not stop conversion");
  cover property (conversionDoneIrq);
  cover property (conversionStart && modeWrite && !modeData[7]);
  cover property ((readHigh || readLow) && conversionStart);
endmodule : adc_conversion_control_asserts
bind adc_conversion_control adc_conversion_control_asserts #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES)) i_adc_conversion_control_asserts (.mclk,
  .srst, .modeWrite, .modeData, .readHigh, .readLow, .flagClear,
  .sampleSwitch, .conversionStart, .converterEnable, .resultHigh,
  .resultLow, .conversionDoneIrq, .conversionDoneFlag);
`default_nettype wire

// File: verif/adc_conversion_control_test.sv
// Bench for the converter control block
// Assumes design and checker compiled before it
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errCount++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module adc_conversion_control_test import adc_conv_pkg::*;;
  logic mclk = 0, srst = 1, modeWrite = 0, chanWrite = 0, flagClear = 0;
  logic readHigh = 0, readLow = 0, sampleSwitch, conversionStart;
  logic converterEnable, conversionDoneIrq, conversionDoneFlag, rnd = 0;
  logic [7:0] modeData = 0, resultHigh;
  logic [2:0] chanData = 0, channel;
  logic [1:0] resultLow;
  logic [9:0] target = 0, tapCode, want, expQ[$];
  logic [9:0] fixed[4] = '{10'h000, 10'h3ff, 10'h200, 10'h1ff};
  wire logic cmpAbove = (tapCode <= target);
  int errCount = 0, comparisons = 0;
  bit seen;
  adc_conversion_control i_adc_conversion_control (.mclk, .srst,
    .modeWrite, .modeData, .chanWrite, .chanData, .readHigh, .readLow,
    .flagClear, .cmpAbove, .sampleSwitch, .tapCode, .channel,
    .conversionStart, .converterEnable, .resultHigh, .resultLow,
    .conversionDoneIrq, .conversionDoneFlag);
  initial forever #10 mclk = ~mclk;
  always @(negedge mclk) begin
    if (conversionDoneIrq === 1'b1) begin
      want = expQ.size() ? expQ.pop_front() : ~{resultHigh, resultLow};
      `CHK({resultHigh, resultLow}, want) // split result
      `CHK(conversionDoneFlag, 1'b1) // flag with irq
    end
  end
  task wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task mode(input logic [7:0] d);
    @(negedge mclk);
    modeWrite = 1;
    modeData = d;
    @(negedge mclk);
    modeWrite = 0;
  endtask : mode
  task strobe(input logic c);
    @(negedge mclk);
    chanWrite = c;
    flagClear = !c;
    @(negedge mclk);
    chanWrite = 0;
    flagClear = 0;
  endtask : strobe
  task waitIrq;
    seen = 0;
    for (int i = 0; i < 200 && !seen; i++) begin
      @(negedge mclk);
      {readHigh, readLow} = rnd ? 2'($urandom) : 2'b00;
      seen = (conversionDoneIrq === 1'b1);
    end
    {readHigh, readLow} = 2'b00;
  endtask : waitIrq
  task convert(input logic [9:0] v);
    target = v;
    expQ.push_back(v);
    mode(8'h81);
    waitIrq();
    `CHK(seen, 1'b1) // one result
    if (!seen) wrap_up();
    @(negedge mclk);
    `CHK(conversionStart, 1'b0) // start cleared
  endtask : convert
  initial begin
    void'($urandom(76));
    repeat (8) @(negedge mclk);
    srst = 0;
    mode(8'h80);
    @(negedge mclk);
    `CHK(conversionStart, 1'b0) // start ignored
    $display("start without enable ended");
    mode(8'h01);
    repeat (5) @(negedge mclk);
    for (int i = 0; i < 4; i++) convert(fixed[i]);
    rnd = 1;
    repeat (6) convert(10'($urandom));
    rnd = 0;
    $display("conversions ended");
    chanData = 3'h5;
    strobe(1);
    `CHK(channel, 3'h5) // channel written
    `CHK(conversionDoneFlag, 1'b1) // flag kept
    strobe(0);
    `CHK(conversionDoneFlag, 1'b0) // flag cleared
    $display("flag test ended");
    mode(8'h81);
    repeat (12) @(negedge mclk);
    mode(8'h01);
    waitIrq();
    `CHK(seen, 1'b0) // no result
    `CHK(conversionStart, 1'b0) // back to standby
    $display("abort test ended");
    mode(8'h00);
    @(negedge mclk);
    `CHK(converterEnable, 1'b0) // converter stopped
    $display("stop test ended");
    wrap_up();
  end
endmodule : adc_conversion_control_test
`default_nettype wire
